/* File: src/mode_ctrl.sv */
// Operating-mode and power-state controller of the transmitter.
// Assumes host commands arrive as one-cycle strobes already decoded from SPI,
// and configuration bits are held stable from nonvolatile storage.
`timescale 1ns/1ps
module mode_ctrl (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic wake_high_pin_i,
  input wire logic [5:0] wake_low_pins_n_i,
  input wire logic cmd_transmit_i,
  input wire logic cmd_calibrate_i,
  input wire logic cmd_exit_i,
  input wire logic cmd_power_off_i,
  input wire logic cfg_xtal_standby_i,
  input wire logic [1:0] cfg_boot_mode_i,
  input wire logic cfg_tune_at_init_i,
  input wire logic [1:0] cfg_sleep_mode_i,
  input wire logic [19:0] cfg_wdog_cycles_i,
  input wire logic wdog_service_i,
  output logic [2:0] mode_o,
  output logic cmd_accept_o,
  output logic mode_done_o,
  output logic digital_supply_domain_o,
  output logic rf_supply_domain_o,
  output logic crystal_osc_o,
  output logic slow_rc_osc_o,
  output logic fast_rc_osc_o,
  output logic cpu_sleep_o,
  output logic [1:0] cpu_sleep_mode_o,
  output logic wdog_restart_o,
  output logic pa_on_o,
  output logic pll_on_o
);
  import mode_pkg::*;

  op_mode_t mode_q;
  op_mode_t mode_d;
  logic [cnt_w-1:0] wait_q;
  logic [cnt_w-1:0] wdog_q;
  logic wdog_fire;
  logic wake;
  logic pending_tune_q;
  logic done_q;
  logic dig_q, rf_q, xto_q, src_q, frc_q, sleep_q;
  tx_seq_if txb();

  // Supply and oscillator set per mode: {dig, rf, xto, src, frc}
  function automatic logic [4:0] supplies(input op_mode_t m, input logic xtal);
    case (m)
      powered_down_state: supplies = 5'h00;
      power_up_state: supplies = 5'h13;
      init_state: supplies = 5'h13;
      standby_state: supplies = xtal ? 5'h1E : 5'h13;
      transmit_state: supplies = 5'h1E;
      tune_check_state: supplies = 5'h1F;
      default: supplies = 5'h00;
    endcase
  endfunction : supplies

  ////////////////////////////////////////////////////////////////////////
  // Wake decode: combinational so it works without any powered-up state
  assign wake = wake_high_pin_i || (wake_low_pins_n_i != 6'h3F);

  // Next-mode logic; standby takes transmit, calibrate and power off, transmit takes only exit
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      powered_down_state: if (wake) mode_d = power_up_state;
      power_up_state: if (wait_q == '0) mode_d = init_state;
      init_state: begin
        if (wait_q == '0) begin
          if (pending_tune_q) mode_d = tune_check_state;
          else if (cfg_boot_mode_i == boot_transmit) mode_d = transmit_state;
          else mode_d = standby_state;
        end
      end
      standby_state: begin
        if (cmd_power_off_i) mode_d = powered_down_state;
        else if (cmd_transmit_i) mode_d = transmit_state;
        else if (cmd_calibrate_i) mode_d = tune_check_state;
      end
      transmit_state: if (cmd_exit_i && !txb.busy) mode_d = standby_state;
      tune_check_state: begin
        if (wait_q == '0) begin
          if (cfg_boot_mode_i == boot_transmit && done_q == 1'b0) mode_d = transmit_state;
          else mode_d = standby_state;
        end
      end
      default: mode_d = powered_down_state;
    endcase
    if (wdog_fire) mode_d = powered_down_state;
  end

  assign cmd_accept_o = (mode_q == standby_state);

  // Mode register, one mode at a time
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      mode_q <= powered_down_state;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Wait counter loaded on entry to timed states
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      wait_q <= '0;
    end else if (mode_d != mode_q) begin
      case (mode_d)
        power_up_state: wait_q <= cnt_w'(reg_settle_cycles - 1);
        init_state: wait_q <= cnt_w'(init_cycles - 1);
        tune_check_state: wait_q <= cnt_w'(tune_cycles - 1);
        default: wait_q <= '0;
      endcase
    end else if (wait_q != '0) begin
      wait_q <= wait_q - 1'b1;
    end
  end

  // Tune at init is latched at wake; done_q marks the boot path finished
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pending_tune_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      if (mode_q == powered_down_state && wake) begin
        pending_tune_q <= cfg_tune_at_init_i;
        done_q <= 1'b0;
      end else if (mode_q == init_state && wait_q == '0) begin
        pending_tune_q <= 1'b0;
      end
      if (mode_q == standby_state || mode_q == transmit_state) done_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Supply and oscillator flops follow the new mode the cycle it is entered
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      {dig_q, rf_q, xto_q, src_q, frc_q} <= 5'h00;
    end else begin
      {dig_q, rf_q, xto_q, src_q, frc_q} <= supplies(mode_d, cfg_xtal_standby_i);
    end
  end

  // Done pulse stands in the first cycle of the new mode, its supplies already set
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      mode_done_o <= 1'b0;
    end else begin
      mode_done_o <= (mode_d != mode_q);
    end
  end

  // Processor sleeps in standby with the configured mode
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      sleep_q <= 1'b0;
      cpu_sleep_mode_o <= sleep_active;
    end else begin
      sleep_q <= (mode_d == standby_state);
      cpu_sleep_mode_o <= cfg_sleep_mode_i;
    end
  end

  // Low-power standby drops the fast RC when the core is in power-down
  assign fast_rc_osc_o = frc_q && !(sleep_q && cpu_sleep_mode_o == sleep_powerdown);
  assign digital_supply_domain_o = dig_q;
  assign rf_supply_domain_o = rf_q;
  assign crystal_osc_o = xto_q;
  assign slow_rc_osc_o = src_q;
  assign cpu_sleep_o = sleep_q;
  assign mode_o = mode_q;

  ////////////////////////////////////////////////////////////////////////
  // Watchdog counts while awake; service reloads, expiry forces restart
  assign wdog_fire = (mode_q != powered_down_state) && (wdog_q == '0) && !wdog_service_i;
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      wdog_q <= cnt_w'(wdog_default_cycles);
      wdog_restart_o <= 1'b0;
    end else begin
      wdog_restart_o <= wdog_fire;
      if (mode_q == powered_down_state || wdog_service_i) begin
        wdog_q <= (cfg_wdog_cycles_i == '0) ? cnt_w'(wdog_default_cycles) : cfg_wdog_cycles_i;
      end else if (wdog_q != '0) begin
        wdog_q <= wdog_q - 1'b1;
      end
    end
  end

  // Transmit path sequencer, enabled by transmit mode
  assign txb.enable = (mode_q == transmit_state);
  tx_path_sequencer u_seq (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .bus(txb.seq)
  );
  assign pa_on_o = txb.pa_on;
  assign pll_on_o = txb.pll_on;

  ////////////////////////////////////////////////////////////////////////
  chk_off_no_cmd: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (mode_q == powered_down_state && !wake) |=> mode_q == powered_down_state)
    else $error("left powered down without wake");
  chk_wake_starts: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (mode_q == powered_down_state && wake) |=> mode_q == power_up_state)
    else $error("wake ignored");
  chk_off_supplies: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (mode_q == powered_down_state && $past(mode_q) == powered_down_state) |->
    !digital_supply_domain_o && !rf_supply_domain_o) else $error("supply on while off");
  chk_rc_standby: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (mode_q == standby_state && !cfg_xtal_standby_i && $stable(cfg_xtal_standby_i)) |->
    !rf_supply_domain_o && !crystal_osc_o && slow_rc_osc_o) else $error("rc standby setting");
  chk_xtal_standby: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (mode_q == standby_state && cfg_xtal_standby_i && $stable(cfg_xtal_standby_i)) |->
    rf_supply_domain_o && crystal_osc_o) else $error("crystal standby setting");
  chk_cmd_only_standby: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (mode_q == transmit_state && cmd_calibrate_i && !cmd_exit_i && !wdog_fire) |=>
    mode_q == transmit_state) else $error("command taken outside standby");
  chk_tx_cmd: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (mode_q == standby_state && cmd_transmit_i && !cmd_power_off_i && !wdog_fire) |=>
    mode_q == transmit_state ##0 rf_supply_domain_o) else $error("transmit command lost");
  chk_wdog_restart: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    wdog_fire |=> wdog_restart_o && mode_q == powered_down_state) else $error("watchdog missed");
  chk_init_standby: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (mode_q == init_state && wait_q == '0 && !pending_tune_q && cfg_boot_mode_i == boot_standby
    && !wdog_fire) |=> mode_q == standby_state) else $error("init did not settle");
  chk_done_pulse: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (mode_q != $past(mode_q)) |-> mode_done_o) else $error("done missing");
  chk_done_supplies: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (mode_done_o && mode_q != powered_down_state) |-> digital_supply_domain_o && slow_rc_osc_o)
    else $error("done before supplies");

  cov_tx: cover property (@(posedge clock_i) mode_q == standby_state ##1 mode_q == transmit_state);
  cov_tune: cover property (@(posedge clock_i) mode_q == tune_check_state);
  cov_wdog: cover property (@(posedge clock_i) wdog_restart_o);
endmodule : mode_ctrl

/* File: src/mode_pkg.sv */
// Constants and types for the operating-mode and power controller.
// Assumes a single 100 MHz clock domain; shared by mode_ctrl and tx_path_sequencer.
package mode_pkg;
  localparam int unsigned clk_period_ns = 10;
  // Regulator settle time after enabling, ns
  localparam int unsigned reg_settle_ns = 2000;
  localparam int unsigned reg_settle_cycles = (reg_settle_ns + clk_period_ns - 1) / clk_period_ns;
  // System initialisation time, ns
  localparam int unsigned init_ns = 5000;
  localparam int unsigned init_cycles = (init_ns + clk_period_ns - 1) / clk_period_ns;
  // Tune-and-check duration, ns
  localparam int unsigned tune_ns = 3000;
  localparam int unsigned tune_cycles = (tune_ns + clk_period_ns - 1) / clk_period_ns;
  // Transmit path sequencer step time, ns
  localparam int unsigned tx_step_ns = 200;
  localparam int unsigned tx_step_cycles = (tx_step_ns + clk_period_ns - 1) / clk_period_ns;
  // Watchdog default time-out in cycles
  localparam int unsigned wdog_default_cycles = 100000;
  localparam int unsigned cnt_w = 20;
  localparam logic [1:0] sleep_active = 2'h0;
  localparam logic [1:0] sleep_powerdown = 2'h1;
  localparam logic [1:0] boot_standby = 2'h0;
  localparam logic [1:0] boot_transmit = 2'h1;

  typedef enum logic [2:0] {
    powered_down_state, power_up_state, init_state, standby_state,
    transmit_state, tune_check_state
  } op_mode_t;

  typedef enum logic [1:0] {
    txs_off, txs_enabling, txs_on, txs_disabling
  } tx_seq_t;
endpackage : mode_pkg

/* File: src/tx_path_sequencer.sv */
// Transmit-path enable/disable sequencer: PLL first, then PA, with a fixed step.
// Assumes synchronous active-high reset and the rf domain on while enabled.
`timescale 1ns/1ps
module tx_path_sequencer (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  tx_seq_if.seq bus
);
  import mode_pkg::*;
  tx_seq_t state_q;
  logic [cnt_w-1:0] step_q;

  ////////////////////////////////////////////////////////////////////////
  // Step sequencer runs on its own, in parallel with the processor
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_q <= txs_off;
      step_q <= '0;
    end else begin
      case (state_q)
        txs_off: begin
          if (bus.enable) begin
            state_q <= txs_enabling;
            step_q <= cnt_w'(tx_step_cycles - 1);
          end
        end
        txs_enabling: begin
          if (step_q == '0) begin
            state_q <= txs_on;
          end else begin
            step_q <= step_q - 1'b1;
          end
        end
        txs_on: begin
          if (!bus.enable) begin
            state_q <= txs_disabling;
            step_q <= cnt_w'(tx_step_cycles - 1);
          end
        end
        txs_disabling: begin
          if (step_q == '0) begin
            state_q <= txs_off;
          end else begin
            step_q <= step_q - 1'b1;
          end
        end
        default: state_q <= txs_off;
      endcase
    end
  end

  // PLL leads on enable and trails on disable so the PA never runs unlocked
  assign bus.pll_on = (state_q != txs_off);
  assign bus.pa_on = (state_q == txs_on);
  assign bus.busy = (state_q == txs_enabling) || (state_q == txs_disabling);

  chk_pa_needs_pll: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    bus.pa_on |-> bus.pll_on) else $error("PA on without PLL");
endmodule : tx_path_sequencer

/* File: src/tx_seq_if.sv */
// Carrier between the mode controller and the transmit path sequencer.
// Assumes both ends share clock_i.
`timescale 1ns/1ps
interface tx_seq_if;
  logic enable;
  logic pa_on;
  logic pll_on;
  logic busy;
  modport ctrl (output enable, input pa_on, input pll_on, input busy);
  modport seq (input enable, output pa_on, output pll_on, output busy);
endinterface : tx_seq_if

/* File: testbench/host_model.sv */
// Host-side model: wake pins, command strobes and watchdog service.
// Assumes the bench calls its tasks; every change lands 1 ns after clock_i rises.
`timescale 1ns/1ps
module host_model (
  input wire logic clock_i,
  output logic wake_high_pin_o,
  output logic [5:0] wake_low_pins_n_o,
  output logic [3:0] cmd_o,
  output logic wdog_service_o
);
  logic svc_en;
  int svc_cnt;

  // Unconnected low wake pins rest high through their pull-ups
  initial begin
    wake_high_pin_o = 1'b0;
    wake_low_pins_n_o = 6'h3F;
    cmd_o = 4'h0;
    wdog_service_o = 1'b0;
    svc_en = 1'b1;
    svc_cnt = 0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Periodic service well inside the reload; cleared by the bench to force expiry
  always @(posedge clock_i) begin
    svc_cnt <= svc_cnt + 1;
    wdog_service_o <= #1 svc_en && (svc_cnt % 500 == 0);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake by the high pin (pin < 0) or by grounding one low pin, held 3 cycles
  task automatic wake(input int pin);
    @(posedge clock_i) #1;
    if (pin < 0) wake_high_pin_o = 1'b1;
    else wake_low_pins_n_o[pin] = 1'b0;
    repeat (3) @(posedge clock_i);
    #1;
    wake_high_pin_o = 1'b0;
    wake_low_pins_n_o = 6'h3F;
  endtask : wake

  // One-cycle strobe: bit0 transmit, bit1 calibrate, bit2 exit, bit3 power off
  task automatic send_cmd(input logic [3:0] sel);
    @(posedge clock_i) #1;
    cmd_o = sel;
    @(posedge clock_i) #1;
    cmd_o = 4'h0;
  endtask : send_cmd
endmodule : host_model

/* File: testbench/tb_top.sv */
// Self-checking bench for the mode and power controller.
// Assumes host_model drives wake and command inputs; config is set while off.
`timescale 1ns/1ps
module tb_top;
  logic clock_i;
  logic sys_rst_i;
  logic cfg_xtal_standby_i;
  logic [1:0] cfg_boot_mode_i;
  logic cfg_tune_at_init_i;
  logic [1:0] cfg_sleep_mode_i;
  logic [19:0] cfg_wdog_cycles_i;
  logic wake_high_pin_i;
  logic [5:0] wake_low_pins_n_i;
  logic [3:0] cmd;
  logic wdog_service_i;
  logic [2:0] mode_o;
  logic cmd_accept_o, mode_done_o, dig, rf, crystal_osc, src, fast_rc_osc;
  logic cpu_sleep_o, wdog_restart_o, pa_on_o, pll_on_o;
  logic [1:0] cpu_sleep_mode_o;
  logic [4:0] pw;
  int n_errors = 0;
  int tests_run = 0;

  assign pw = {dig, rf, crystal_osc, src, fast_rc_osc};

  // 100 MHz clock
  always #5 clock_i = ~clock_i;

  host_model i_host (.clock_i(clock_i), .wake_high_pin_o(wake_high_pin_i),
    .wake_low_pins_n_o(wake_low_pins_n_i), .cmd_o(cmd), .wdog_service_o(wdog_service_i));

  mode_ctrl i_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .wake_high_pin_i(wake_high_pin_i),
    .wake_low_pins_n_i(wake_low_pins_n_i), .cmd_transmit_i(cmd[0]), .cmd_calibrate_i(cmd[1]),
    .cmd_exit_i(cmd[2]), .cmd_power_off_i(cmd[3]), .cfg_xtal_standby_i(cfg_xtal_standby_i),
    .cfg_boot_mode_i(cfg_boot_mode_i), .cfg_tune_at_init_i(cfg_tune_at_init_i),
    .cfg_sleep_mode_i(cfg_sleep_mode_i), .cfg_wdog_cycles_i(cfg_wdog_cycles_i), .wdog_service_i(wdog_service_i),
    .mode_o(mode_o), .cmd_accept_o(cmd_accept_o), .mode_done_o(mode_done_o),
    .digital_supply_domain_o(dig), .rf_supply_domain_o(rf), .crystal_osc_o(crystal_osc),
    .slow_rc_osc_o(src), .fast_rc_osc_o(fast_rc_osc), .cpu_sleep_o(cpu_sleep_o),
    .cpu_sleep_mode_o(cpu_sleep_mode_o), .wdog_restart_o(wdog_restart_o),
    .pa_on_o(pa_on_o), .pll_on_o(pll_on_o));

  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input logic [19:0] got, input logic [19:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Bounded wait for a mode; a miss shows up as a mismatch
  task automatic wait_mode(input logic [2:0] m, input int lim);
    for (int i = 0; i < lim && mode_o !== m; i++) @(posedge clock_i) #1;
    check(mode_o, m);
  endtask : wait_mode

  task automatic stop_test();
    $display("comparisons=%0d mismatches=%0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog of 20000 cycles, about five times what the tests take
  initial begin
    #200000;
    n_errors++;
    stop_test();
  end

  // Main sequence
  initial begin
    clock_i = 1'b0;
    sys_rst_i = 1'b1;
    cfg_xtal_standby_i = 1'b0;
    cfg_boot_mode_i = 2'h0;
    cfg_tune_at_init_i = 1'b0;
    cfg_sleep_mode_i = 2'h1;
    cfg_wdog_cycles_i = 20'h00BB8;
    repeat (5) @(posedge clock_i);
    #1 sys_rst_i = 1'b0;
    check({mode_o, pw, cmd_accept_o}, 9'h000);
    i_host.send_cmd(4'h1);
    check(mode_o, 3'h0);
    i_host.wake(3);
    wait_mode(3'h1, 5);
    check(pw, 5'h13);
    wait_mode(3'h3, 800);
    check(pw, 5'h12);
    check({cpu_sleep_o, cpu_sleep_mode_o, cmd_accept_o}, 4'hB);
    // Calibration leaves standby and comes back on its own
    i_host.send_cmd(4'h2);
    check({mode_o, mode_done_o}, 4'hB);
    wait_mode(3'h3, 400);
    // Transmit wins over calibrate when both strobe together
    i_host.send_cmd(4'h3);
    check({mode_o, pw}, 8'h9E);
    // Exit is refused while the sequencer is still stepping up
    i_host.send_cmd(4'h4);
    check(mode_o, 3'h4);
    repeat (25) @(posedge clock_i);
    #1;
    check({pll_on_o, pa_on_o}, 2'h3);
    i_host.send_cmd(4'h2);
    check(mode_o, 3'h4);
    // Exit drops the amplifier before the synthesiser
    i_host.send_cmd(4'h4);
    repeat (5) @(posedge clock_i);
    #1;
    check({pll_on_o, pa_on_o}, 2'h2);
    wait_mode(3'h3, 100);
    // Synthesiser trails the amplifier by one full step
    repeat (16) @(posedge clock_i);
    #1;
    check({pll_on_o, pa_on_o}, 2'h0);
    i_host.send_cmd(4'h8);
    check({mode_o, pw}, 8'h00);
    // Crystal standby with an active processor, woken by the high pin
    cfg_xtal_standby_i = 1'b1;
    cfg_sleep_mode_i = 2'h0;
    i_host.wake(-1);
    wait_mode(3'h3, 800);
    check({pw, cpu_sleep_mode_o}, 7'h78);
    i_host.send_cmd(4'h8);
    check(mode_o, 3'h0);
    // Boot straight to transmit after tune-at-init
    cfg_boot_mode_i = 2'h1;
    cfg_tune_at_init_i = 1'b1;
    cfg_wdog_cycles_i = 20'h00400;
    i_host.wake(0);
    wait_mode(3'h5, 800);
    wait_mode(3'h4, 400);
    // Missed service restarts the device into the powered-down state
    // Service stops right after a pulse; expiry is due reload plus two edges later
    @(posedge wdog_service_i);
    i_host.svc_en = 1'b0;
    repeat (1025) @(posedge clock_i);
    #1;
    check(wdog_restart_o, 1'b0);
    @(posedge clock_i) #1;
    check(wdog_restart_o, 1'b1);
    wait_mode(3'h0, 3);
    check(pw, 5'h00);
    stop_test();
  end
endmodule : tb_top
